// [hdl/iwdt_pkg.sv]
package iwdt_pkg;

  localparam int IWDT_WORD_W = 24;
  localparam int IWDT_OPC_W = 8;
  localparam int IWDT_OPC_LSB = 16;
  localparam int IWDT_OPR_W = 16;
  localparam logic [7:0] IWDT_SECOND_WORD_OPC = 8'h00;
  localparam logic [1:0] IWDT_CYC_ONE = 2'h1;
  localparam logic [1:0] IWDT_CYC_TWO = 2'h2;
  localparam logic [1:0] IWDT_CYC_THREE = 2'h3;

  typedef enum logic [2:0] {
    IWDT_CAT_NONE,
    IWDT_CAT_WORD_REG,
    IWDT_CAT_WORD_MEM,
    IWDT_CAT_BIT,
    IWDT_CAT_LIT_MOVE,
    IWDT_CAT_LIT_ALU,
    IWDT_CAT_CONTROL
  } iwdt_cat_t;

  typedef enum logic [2:0] {
    IWDT_FLOW_NONE,
    IWDT_FLOW_CONDITIONAL,
    IWDT_FLOW_SKIP,
    IWDT_FLOW_JUMP_LONG,
    IWDT_FLOW_PC_WRITE
  } iwdt_flow_t;

  // class of a fetched opcode, supplied by the opcode table outside this block
  typedef struct packed {
    iwdt_cat_t cat;
    iwdt_flow_t flow;
    logic two_word;
    logic bit_from_reg;
    logic dst_is_mem;
    logic table_mode;
  } iwdt_class_t;

  typedef struct packed {
    logic valid;
    logic is_nop;
    iwdt_cat_t cat;
    logic [7:0] opcode;
    logic [3:0] base_source_register;
    logic [6:0] second_source_register;
    logic [6:0] result_register;
    logic write_result;
    logic [12:0] mem_addr;
    logic dst_working_zero_alias;
    logic [3:0] bit_pos;
    logic bit_from_reg;
    logic [15:0] literal;
    logic [22:0] prog_addr;
    logic [1:0] table_mode;
    logic [1:0] cycles;
  } iwdt_dec_t;

endpackage : iwdt_pkg

// [hdl/iwdt_decoder.sv]
// Functional notes
// [RQ1] accept 24-bit program memory words
// [RQ2] top 8 bits opcode, rest operands
// [RQ3] three instructions span two words
// [RQ4] second word upper 8 bits zero
// [RQ5] lone second word executes as nop
// [RQ6] plain single word takes one cycle
// [RQ7] true condition or pc change: two cycles
// [RQ8] jumps, tables, returns take two/three cycles
// [RQ9] taken skip: two or three cycles
// [RQ10] double-word instructions take two cycles
// [RQ11] register ops decode three operands
// [RQ12] memory ops: address plus destination select
// [RQ13] bit ops: operand plus bit position
// [RQ14] literal moves load register or memory
// [RQ15] literal alu writes result if distinct
// [RQ16] control: program address or table mode
// [RQ17] second word consumed, never issued alone
`timescale 1ns/1ps
module iwdt_decoder
  import iwdt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_word,
  input wire iwdt_pkg::iwdt_class_t fetch_class,
  input wire logic cond_true,
  input wire logic next_is_two_word,
  input wire logic sequential,
  output iwdt_pkg::iwdt_dec_t dec_out
);
  import iwdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n_int = rst_s2_r;

  ////////////////////////////////////////////////////////////////////////
  // field split of one word
  wire [7:0] opc = fetch_word[IWDT_OPC_LSB +: IWDT_OPC_W]; // RQ1 RQ2
  wire [15:0] opr = fetch_word[IWDT_OPR_W-1:0]; // RQ2

  // a second word is pending when the previous word opened a two-word instruction
  logic pend_second_r;
  logic [15:0] first_opr_r;
  iwdt_class_t first_cls_r;
  logic [7:0] first_opc_r;

  wire take_word = fetch_valid;
  wire is_second = pend_second_r && sequential; // RQ17
  wire opens_two = take_word && !is_second && fetch_class.two_word; // RQ3
  // lone second word (pc landed on it): upper byte zero reads as nop
  // a pending pair broken by a jump does not shield a lone second word
  wire lone_nop = take_word && !is_second && (opc == IWDT_SECOND_WORD_OPC) && !fetch_class.two_word; // RQ4 RQ5

  wire iwdt_class_t cls = is_second ? first_cls_r : fetch_class;
  wire [7:0] opc_eff = is_second ? first_opc_r : opc;
  wire [15:0] w1 = is_second ? first_opr_r : opr;

  ////////////////////////////////////////////////////////////////////////
  // cycle count
  logic [1:0] cyc;
  always_comb begin
    cyc = IWDT_CYC_ONE; // RQ6
    case (cls.flow)
      IWDT_FLOW_NONE: cyc = IWDT_CYC_ONE; // RQ6
      IWDT_FLOW_CONDITIONAL: cyc = cond_true ? IWDT_CYC_TWO : IWDT_CYC_ONE; // RQ7
      IWDT_FLOW_PC_WRITE: cyc = IWDT_CYC_TWO; // RQ7 RQ8
      IWDT_FLOW_JUMP_LONG: cyc = IWDT_CYC_THREE; // RQ8
      IWDT_FLOW_SKIP: begin
        if (!cond_true) cyc = IWDT_CYC_ONE;
        else if (next_is_two_word) cyc = IWDT_CYC_THREE; // RQ9
        else cyc = IWDT_CYC_TWO; // RQ9
      end
      default: cyc = IWDT_CYC_ONE;
    endcase
    if (cls.two_word) cyc = IWDT_CYC_TWO; // RQ10
  end

  ////////////////////////////////////////////////////////////////////////
  // operand decode
  iwdt_dec_t d;
  always_comb begin
    d = '0;
    d.cat = cls.cat;
    d.opcode = opc_eff;
    d.cycles = cyc;
    case (cls.cat)
      IWDT_CAT_WORD_REG: begin
        d.base_source_register = w1[14:11]; // RQ11
        d.second_source_register = w1[6:0]; // RQ11
        d.result_register = w1[13:7]; // RQ11
        d.write_result = 1'b1;
      end
      IWDT_CAT_WORD_MEM: begin
        d.mem_addr = w1[12:0]; // RQ12
        d.dst_working_zero_alias = !w1[13]; // RQ12
        d.write_result = 1'b1;
      end
      IWDT_CAT_BIT: begin
        d.second_source_register = w1[6:0]; // RQ13
        d.mem_addr = w1[12:0];
        d.bit_from_reg = cls.bit_from_reg; // RQ13
        d.bit_pos = w1[15:12];
        d.base_source_register = w1[14:11];
      end
      IWDT_CAT_LIT_MOVE: begin
        d.literal = w1; // RQ14
        d.result_register = {3'h0, w1[3:0]};
        d.mem_addr = w1[12:0];
        d.write_result = 1'b1; // RQ14
      end
      IWDT_CAT_LIT_ALU: begin
        d.base_source_register = w1[14:11]; // RQ15
        d.literal = {6'h00, w1[9:0]}; // RQ15
        d.result_register = {3'h0, w1[3:0]};
        d.write_result = (w1[3:0] != w1[14:11]); // RQ15
      end
      IWDT_CAT_CONTROL: begin
        if (cls.table_mode) d.table_mode = w1[1:0]; // RQ16
        else if (is_second) d.prog_addr = {fetch_word[6:0], first_opr_r}; // RQ16
        else d.prog_addr = {7'h00, w1}; // RQ16
      end
      default: d.write_result = 1'b0;
    endcase
    d.valid = take_word && !opens_two && !lone_nop; // RQ17
    d.is_nop = lone_nop; // RQ5
    if (lone_nop) d.cycles = IWDT_CYC_ONE;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pend_second_r <= 1'b0;
      first_opr_r <= 16'h0000;
      first_cls_r <= '0;
      first_opc_r <= 8'h00;
      dec_out <= '0;
    end else begin
      if (take_word) pend_second_r <= opens_two; // RQ3 RQ17
      if (opens_two) begin
        first_opr_r <= opr;
        first_cls_r <= fetch_class;
        first_opc_r <= opc;
      end
      dec_out <= d;
    end
  end

endmodule : iwdt_decoder

// [dv/iwdt_decoder_properties.sv]
`timescale 1ns/1ps
module iwdt_decoder_properties
  import iwdt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_word,
  input wire iwdt_pkg::iwdt_class_t fetch_class,
  input wire logic cond_true,
  input wire logic next_is_two_word,
  input wire logic sequential,
  input wire iwdt_pkg::iwdt_dec_t dec_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // a jump target cannot complete a pending pair
  wire nw = fetch_valid && !sequential && !fetch_class.two_word;
  wire op0 = fetch_word[23:16] == 8'h00;
  sequence s_first; fetch_valid && fetch_class.two_word; endsequence
  sequence s_pair; s_first ##1 (fetch_valid && sequential); endsequence
  property p_opc; nw && !op0 |=> dec_out.opcode == $past(fetch_word[23:16]); endproperty
  a_opc: assert property (p_opc) else $error("bad opcode");
  property p_one; nw && !op0 && fetch_class.flow == IWDT_FLOW_NONE |=> dec_out.cycles == IWDT_CYC_ONE; endproperty
  a_one: assert property (p_one) else $error("bad one");
  property p_cond; nw && fetch_class.flow == IWDT_FLOW_CONDITIONAL && cond_true |=> dec_out.cycles == 2'h2; endproperty
  a_cond: assert property (p_cond) else $error("bad cond");
  property p_jump; nw && fetch_class.flow == IWDT_FLOW_JUMP_LONG |=> dec_out.cycles == 2'h3; endproperty
  a_jump: assert property (p_jump) else $error("bad jump");
  property p_skip; nw && fetch_class.flow == IWDT_FLOW_SKIP && cond_true && next_is_two_word |=> dec_out.cycles == 2'h3;
  endproperty
  a_skip: assert property (p_skip) else $error("bad skip");
  property p_nop; nw && op0 |=> dec_out.is_nop && !dec_out.valid; endproperty
  a_nop: assert property (p_nop) else $error("bad nop");
  property p_first; s_first |=> !dec_out.valid; endproperty
  a_first: assert property (p_first) else $error("first issued");
  property p_pair; s_pair |=> dec_out.valid && dec_out.cycles == 2'h2; endproperty
  a_pair: assert property (p_pair) else $error("bad pair");
endmodule : iwdt_decoder_properties
bind iwdt_decoder iwdt_decoder_properties u_props (.*);

// [dv/iwdt_fetch_model.sv]
`timescale 1ns/1ps
module iwdt_fetch_model (
  input wire logic mclk,
  input wire logic req_valid,
  input wire logic [23:0] req_word,
  output logic fetch_valid,
  output logic [23:0] fetch_word
);
  logic [23:0] last_r = 24'h0;
  always @(posedge mclk) if (req_valid) last_r <= req_word;
  assign fetch_valid = req_valid;
  // idle bus shows the inverted last word, so a stale sample never matches
  assign fetch_word = req_valid ? req_word : ~last_r;
endmodule : iwdt_fetch_model

// [dv/instruction_word_decode_timing_tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin mismatches++; $display("MISMATCH %s %0h %0h", n, e, a); end end
module instruction_word_decode_timing_tb;
  import iwdt_pkg::*;
  logic mclk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, cond_true = 1'b0, next_is_two_word = 1'b0, sequential = 1'b0;
  logic fetch_valid;
  logic [23:0] req_word = 24'h0, fetch_word;
  iwdt_class_t fetch_class = '0;
  iwdt_dec_t dec_out;
  int mismatches = 0, num_checks = 0;
  // flow, condition true, two-word after skip, expected cycles
  logic [6:0] rows [8] = '{7'h01, 7'h11, 7'h1a, 7'h42, 7'h33, 7'h21, 7'h2a, 7'h2f};
  initial forever #12.5 mclk = ~mclk;
  iwdt_fetch_model u_fetch (.*);
  iwdt_decoder u_dut (.*);
  task automatic go(input logic [23:0] wd, input iwdt_cat_t c, input logic [2:0] f, input logic [3:0] m);
    req_valid = 1'b1;
    req_word = wd;
    fetch_class = '{c, iwdt_flow_t'(f), m[3], 1'b0, 1'b0, 1'b0};
    {cond_true, next_is_two_word, sequential} = m[2:0];
    @(posedge mclk);
    #2;
  endtask : go
  task automatic t_cycles;
    for (int i = 0; i < 8; i++) begin
      go({8'h10 + 8'(i), 16'h5a3c}, IWDT_CAT_CONTROL, rows[i][6:4], {1'b0, rows[i][3:2], 1'b0});
      `CHK("cyc", rows[i][1:0], dec_out.cycles)
    end
  endtask : t_cycles
  task automatic t_fields;
    go(24'h315a3c, IWDT_CAT_WORD_REG, 3'h0, 4'h0);
    `CHK("base", 4'hb, dec_out.base_source_register)
    `CHK("res", 7'h34, dec_out.result_register)
    `CHK("opc", 8'h31, dec_out.opcode)
    go(24'h325a3c, IWDT_CAT_WORD_MEM, 3'h0, 4'h1);
    `CHK("mem", 13'h1a3c, dec_out.mem_addr)
    go(24'h335a3c, IWDT_CAT_BIT, 3'h0, 4'h0);
    `CHK("bpos", 4'h5, dec_out.bit_pos)
    go(24'h345a3c, IWDT_CAT_LIT_MOVE, 3'h0, 4'h0);
    `CHK("lmov", 16'h5a3c, dec_out.literal)
    go(24'h355a3c, IWDT_CAT_LIT_ALU, 3'h0, 4'h0);
    `CHK("lalu", 16'h023c, dec_out.literal)
    `CHK("wres", 1'b1, dec_out.write_result)
    go(24'h355a3b, IWDT_CAT_LIT_ALU, 3'h0, 4'h0);
    `CHK("wsame", 1'b0, dec_out.write_result)
  endtask : t_fields
  task automatic t_pair;
    go(24'h021234, IWDT_CAT_CONTROL, 3'h3, 4'h8);
    `CHK("first", 1'b0, dec_out.valid)
    go(24'h000045, IWDT_CAT_NONE, 3'h0, 4'h1);
    `CHK("pair", 1'b1, dec_out.valid)
    `CHK("addr", 23'h451234, dec_out.prog_addr)
    `CHK("pcyc", 2'h2, dec_out.cycles)
    go(24'h000045, IWDT_CAT_NONE, 3'h0, 4'h0);
    `CHK("nop", 1'b1, dec_out.is_nop)
    go(24'h021234, IWDT_CAT_CONTROL, 3'h3, 4'h8);
    go(24'h000045, IWDT_CAT_NONE, 3'h0, 4'h0);
    `CHK("jnop", 1'b1, dec_out.is_nop)
    `CHK("jval", 1'b0, dec_out.valid)
  endtask : t_pair
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (20) @(posedge mclk);
    #2 rst_b = 1'b1;
    repeat (3) @(posedge mclk);
    #2;
    t_cycles();
    t_fields();
    t_pair();
    req_valid = 1'b0;
    @(posedge mclk);
    test_done();
  end
endmodule : instruction_word_decode_timing_tb
